//--- src/spi_feram_command_core.sv
// serial memory slave: opcode decode, protection_status, array access sequencing
module spi_feram_command_core
  import spi_feram_pkg::*;
#(
  parameter logic [31:0] DEVICE_IDENT = DEVICE_IDENT_DEFAULT
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // serial pins
  input  wire logic                    cs_n_i,
  input  wire logic                    sck_i,
  input  wire logic                    si_i,
  input  wire logic                    wp_n_i,
  output logic                         so_o,
  output logic                         so_oe_o,
  // array port
  output logic [ARRAY_ADDR_W-1:0]      mem_addr_o,
  output logic                         mem_re_o,
  output logic                         mem_we_o,
  output logic [7:0]                   mem_wdata_o,
  input  wire logic [7:0]              mem_rdata_i
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [3:0] pins_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       wp_n_s;

  // cs and wp idle high so reset does not fake a selection
  pin_sync #(
    .W       (4),
    .RST_VAL (4'b1001)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({cs_n_i, sck_i, si_i, wp_n_i}),
    .sync_o    (pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sck_s  = pins_s[2];
  assign si_s   = pins_s[1];
  assign wp_n_s = pins_s[0];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // upper region protected according to the block-protect pair
  function automatic logic is_protected(input logic [1:0] bp, input logic [ARRAY_ADDR_W-1:0] a);
    logic p;
    p = 1'b0;
    case (bp)
      BP_NONE:    p = 1'b0;
      BP_QUARTER: p = a[ARRAY_ADDR_W-1] & a[ARRAY_ADDR_W-2];
      BP_HALF:    p = a[ARRAY_ADDR_W-1];
      default:    p = 1'b1;
    endcase
    return p;
  endfunction

  function automatic logic [ARRAY_ADDR_W-1:0] next_addr(input logic [ARRAY_ADDR_W-1:0] a);
    return ARRAY_ADDR_W'(a + 1'b1);
  endfunction

  core_state_t q;
  core_state_t d;
  logic        rise;
  logic        fall;
  logic [7:0]  in_byte;
  logic [7:0]  status_byte;
  logic [1:0]  bp;
  logic        status_writable;

  assign rise        = sck_s & ~q.sck_prev;
  assign fall        = ~sck_s & q.sck_prev;
  assign in_byte     = {q.sh[6:0], si_s};
  assign status_byte = {q.nvs, q.wr_latch, 1'b0};
  assign bp          = q.nvs[STAT_BP_HI-STAT_NV_LO -: 2];
  // pin low with protect-enable set locks the status byte
  assign status_writable = q.wr_latch & ~(q.nvs[STAT_LOCK_BIT-STAT_NV_LO] & ~wp_n_s);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    d          = q;
    d.sck_prev = sck_s;
    d.re       = 1'b0;
    d.we       = 1'b0;
    d.load     = q.re;
    // read data arrives one cycle after the request
    if (q.load) begin
      d.osh = {mem_rdata_i, 24'h00_0000};
    end
    if (cs_n_s) begin
      // deselect drops any partial opcode or byte
      d.st   = ST_OPC;
      d.cnt  = '0;
      d.ocnt = '0;
    end else begin
      if (rise) begin
        d.sh  = in_byte;
        d.cnt = 6'(q.cnt + 1'b1);
        case (q.st)
          ST_OPC: begin
            if (q.cnt == OPC_LAST) begin
              d.cnt = '0;
              d.op  = in_byte;
              d.st  = ST_IGNORE;
              case (in_byte)
                SET_LATCH_CMD:   d.wr_latch = 1'b1;
                CLEAR_LATCH_CMD: d.wr_latch = 1'b0;
                STATUS_READ_CMD: begin
                  d.st  = ST_DOUT;
                  d.osh = {status_byte, 24'h00_0000};
                end
                STATUS_WRITE_CMD: d.st = ST_DIN;
                ARRAY_READ_CMD,
                FAST_ARRAY_READ_CMD,
                ARRAY_WRITE_CMD:  d.st = ST_ADDR;
                DEVICE_IDENT_READ_CMD: begin
                  d.st  = ST_DOUT;
                  d.osh = DEVICE_IDENT;
                end
                // decoded, handled by the neighbouring sequencers; latch left as is
                UNIQUE_IDENT_READ_CMD, SERIAL_NUMBER_WRITE_CMD,
                SERIAL_NUMBER_READ_CMD: d.st = ST_IGNORE;
                SPECIAL_SECTOR_WRITE_CMD, SPECIAL_SECTOR_READ_CMD,
                FAST_SPECIAL_SECTOR_READ_CMD: d.st = ST_IGNORE;
                // reserved codes: recognised, rest of frame ignored
                RESERVED_CODE_A, RESERVED_CODE_B,
                RESERVED_CODE_C: d.st = ST_IGNORE;
                default: d.st = ST_IGNORE; // unlisted codes
              endcase
            end
          end
          ST_ADDR: begin
            // shifting into 19 bits drops the top five address bits
            d.addr = {q.addr[ARRAY_ADDR_W-2:0], si_s};
            if (q.cnt == ADDR_LAST) begin
              d.cnt = '0;
              if (q.op == ARRAY_WRITE_CMD) begin
                d.st = ST_DIN;
              end else if (q.op == FAST_ARRAY_READ_CMD) begin
                d.st = ST_DUMMY;
              end else begin
                d.st    = ST_DOUT;
                d.re    = 1'b1;
                d.maddr = {q.addr[ARRAY_ADDR_W-2:0], si_s};
              end
            end
          end
          ST_DUMMY: begin
            if (q.cnt == DUMMY_LAST) begin
              d.cnt   = '0;
              d.st    = ST_DOUT;
              d.re    = 1'b1;
              d.maddr = q.addr;
            end
          end
          ST_DIN: begin
            if (q.cnt == BYTE_LAST) begin
              d.cnt = '0;
              if (q.op == STATUS_WRITE_CMD) begin
                d.st = ST_IGNORE;
                if (status_writable) begin
                  d.nvs = in_byte[7:STAT_NV_LO];
                end
              end else begin
                // commit at the eighth bit, then step with natural wrap
                if (q.wr_latch && !is_protected(bp, q.addr)) begin
                  d.we    = 1'b1;
                  d.wdata = in_byte;
                  d.maddr = q.addr;
                end
                d.addr = next_addr(q.addr);
              end
            end
          end
          default: ; // ignore state: input discarded until deselect
        endcase
      end
      // output shifts on falling edges only, input ignored meanwhile
      if (fall && q.st == ST_DOUT) begin
        if (!(q.op == DEVICE_IDENT_READ_CMD && q.ocnt == IDENT_BITS)) begin
          d.so   = q.osh[31];
          d.osh  = {q.osh[30:0], 1'b0};
          d.ocnt = 6'(q.ocnt + 1'b1);
          if (q.op != DEVICE_IDENT_READ_CMD && q.ocnt[2:0] == OUT_BYTE_END) begin
            if (q.op == STATUS_READ_CMD) begin
              d.osh = {status_byte, 24'h00_0000};
            end else begin
              // prefetch next byte well before the next falling edge
              d.re    = 1'b1;
              d.addr  = next_addr(q.addr);
              d.maddr = next_addr(q.addr);
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // nonvolatile bits take a reset image; real retention sits outside this core
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q          <= '0;
      q.st       <= ST_OPC;
      q.nvs      <= NV_STATUS_RST;
      q.wr_latch <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign so_o        = q.so;
  assign so_oe_o     = (q.st == ST_DOUT);
  assign mem_addr_o  = q.maddr;
  assign mem_re_o    = q.re;
  assign mem_we_o    = q.we;
  assign mem_wdata_o = q.wdata;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_opcode(logic [7:0] c);
    !cs_n_s && q.st == ST_OPC && rise && q.cnt == OPC_LAST && in_byte == c;
  endsequence

  sequence s_status_byte_done;
    !cs_n_s && q.st == ST_DIN && q.op == STATUS_WRITE_CMD && rise && q.cnt == BYTE_LAST;
  endsequence

  property p_latch_set;
    s_opcode(SET_LATCH_CMD) |=> q.wr_latch ##1 q.wr_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_clear;
    s_opcode(CLEAR_LATCH_CMD) |=> !q.wr_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_bit0_zero;
    (q.st == ST_DOUT && q.op == STATUS_READ_CMD && !cs_n_s && fall && q.ocnt[2:0] == OUT_BYTE_END) |=> !so_o;
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("status bit 0 not zero");

  property p_status_locked;
    (s_status_byte_done and (!status_writable)) |=> $stable(q.nvs);
  endproperty
  a_status_locked: assert property (p_status_locked) else $error("locked status changed");

  property p_status_taken;
    (s_status_byte_done and status_writable) |=> q.nvs == $past(in_byte[7:STAT_NV_LO]) && q.wr_latch;
  endproperty
  a_status_taken: assert property (p_status_taken) else $error("status byte not taken");

  property p_write_allowed;
    mem_we_o |-> $past(q.wr_latch) && !is_protected($past(bp), mem_addr_o);
  endproperty
  a_write_allowed: assert property (p_write_allowed) else $error("blocked array write");

  property p_deselect_idle;
    cs_n_s |=> !so_oe_o && q.cnt == '0 && !mem_we_o;
  endproperty
  a_deselect_idle: assert property (p_deselect_idle) else $error("not idle while deselected");

  property p_out_on_fall;
    $changed(q.so) |-> $past(fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off falling edge");

  property p_ident_hold;
    (q.st == ST_DOUT && q.op == DEVICE_IDENT_READ_CMD && q.ocnt == IDENT_BITS && !cs_n_s) |=> $stable(q.so);
  endproperty
  a_ident_hold: assert property (p_ident_hold) else $error("identifier last bit not held");

  property p_write_step;
    mem_we_o |-> q.addr == next_addr(mem_addr_o);
  endproperty
  a_write_step: assert property (p_write_step) else $error("write address not stepped");

endmodule // spi_feram_command_core

//--- common/spi_feram_pkg.sv
// constants, opcodes and state types for the serial nonvolatile memory command core
//
// Behaviour
// - bit 7 protect-enable, gates status writes with pin
// - bits 6..4 stored, read back, no function
// - bits 3..2 block protect, written and read
// - bit 1 latch: set, clear, reset, read only
// - latch stays set after write commands complete
// - bit 0 always reads zero
// - first eight bits are opcode; seventeen codes decoded
// - select rising mid-opcode performs no command
// - special-sector opcodes decoded
// - unique-ID and serial-number opcodes decoded
// - set-latch sets latch before any write
// - cleared latch blocks every write
// - status read shifts byte repeatedly, input ignored
// - status write takes byte, ignores bits 1,0
// - array read: 24-bit address, top five ignored
// - reads auto-increment and wrap to zero
// - array write commits each byte at bit eight
// - writes auto-increment and wrap to zero
// - fast read adds eight dummy bits
// - identifier read shifts 32 bits, holds last
// - sample input rising, change output falling
// - deselected: output released, inputs ignored
// - block-protect pair selects protected upper region
// - latch gates array and status writes; pin gates status writes only
package spi_feram_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] SET_LATCH_CMD                = 8'h06;
  localparam logic [7:0] CLEAR_LATCH_CMD              = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD              = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD             = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD               = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD              = 8'h02;
  localparam logic [7:0] FAST_ARRAY_READ_CMD          = 8'h0B;
  localparam logic [7:0] DEVICE_IDENT_READ_CMD        = 8'h9F;
  localparam logic [7:0] UNIQUE_IDENT_READ_CMD        = 8'h4C;
  localparam logic [7:0] SERIAL_NUMBER_WRITE_CMD      = 8'hC2;
  localparam logic [7:0] SERIAL_NUMBER_READ_CMD       = 8'hC3;
  localparam logic [7:0] SPECIAL_SECTOR_WRITE_CMD     = 8'h42;
  localparam logic [7:0] SPECIAL_SECTOR_READ_CMD      = 8'h4B;
  localparam logic [7:0] FAST_SPECIAL_SECTOR_READ_CMD = 8'h49;
  localparam logic [7:0] RESERVED_CODE_A              = 8'hCE;
  localparam logic [7:0] RESERVED_CODE_B              = 8'hCF;
  localparam logic [7:0] RESERVED_CODE_C              = 8'hCC;

  // ---------------------------------------------------------------
  // frame lengths and widths
  // ---------------------------------------------------------------
  localparam int         ARRAY_ADDR_W = 19;
  localparam logic [5:0] OPC_LAST     = 6'd7;
  localparam logic [5:0] ADDR_LAST    = 6'd23;
  localparam logic [5:0] DUMMY_LAST   = 6'd7;
  localparam logic [5:0] BYTE_LAST    = 6'd7;
  localparam logic [2:0] OUT_BYTE_END = 3'd7;
  localparam logic [5:0] IDENT_BITS   = 6'd32;

  // ---------------------------------------------------------------
  // protection_status layout
  // ---------------------------------------------------------------
  localparam int         STAT_LOCK_BIT = 7;
  localparam int         STAT_BP_HI    = 3;
  localparam int         STAT_BP_LO    = 2;
  localparam int         STAT_NV_LO    = 2;
  localparam logic [5:0] NV_STATUS_RST = 6'h00;
  localparam logic [1:0] BP_NONE       = 2'b00;
  localparam logic [1:0] BP_QUARTER    = 2'b01;
  localparam logic [1:0] BP_HALF       = 2'b10;
  localparam logic [1:0] BP_QUARTER_HI = 2'b11;

  // arbitrary neutral identifier value
  localparam logic [31:0] DEVICE_IDENT_DEFAULT = 32'h5A01_C3E7;

  // ---------------------------------------------------------------
  // command states, gray along opcode-address-dummy-output
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPC    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b011,
    ST_DOUT   = 3'b010,
    ST_DIN    = 3'b110,
    ST_IGNORE = 3'b111
  } cmd_state_t;

  typedef struct packed {
    cmd_state_t              st;
    logic [5:0]              cnt;
    logic [7:0]              sh;
    logic [7:0]              op;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [ARRAY_ADDR_W-1:0] maddr;
    logic [5:0]              nvs;
    logic                    wr_latch;
    logic [31:0]             osh;
    logic [5:0]              ocnt;
    logic                    so;
    logic                    sck_prev;
    logic                    re;
    logic                    load;
    logic                    we;
    logic [7:0]              wdata;
  } core_state_t;

endpackage

//--- src/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // pin_sync

//--- dv/spi_host_model.sv
// host side of the serial link: select, clock and data in mode 0 or 3
module spi_host_model (
  // clock
  input  wire logic clk_i,
  // serial pins
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;

  logic so_w;
  logic idle_high = 1'b0;

  // a released output line floats to the pull-up level
  assign so_w = so_oe_i ? so_i : 1'b1;

  // clock parked at its idle level outside frames
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // every change lands just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // polarity only changes while deselected; that edge must be ignored
  task automatic set_mode(input logic m);
    tick(1);
    idle_high = m;
    sck_o     = m;
  endtask

  // select settles before the first clock rise
  task automatic start();
    tick(1);
    cs_n_o = 1'b0;
    tick(4);
  endtask

  // four system clocks per link half period; sample late, just before the fall
  task automatic bit_x(input logic b, output logic r);
    if (idle_high) sck_o = 1'b0;
    si_o = b;
    tick(4);
    sck_o = 1'b1;
    tick(3);
    r = so_w;
    tick(1);
    if (!idle_high) sck_o = 1'b0;
  endtask

  // whole bytes, msb first, eight clocks each
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask

  // deselect long enough for the synchroniser to see it
  task automatic stop();
    tick(4);
    cs_n_o = 1'b1;
    tick(6);
  endtask
endmodule // spi_host_model

//--- dv/tb_top.sv
// self-checking bench for the serial memory command core
module tb_top import spi_feram_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // signals and models
  // ---------------------------------------------------------------
  // decoded-only codes; reserved codes are never sent, the host may not use them
  localparam logic [7:0] DEC_ONLY [6] = '{UNIQUE_IDENT_READ_CMD, SERIAL_NUMBER_WRITE_CMD,
    SERIAL_NUMBER_READ_CMD, SPECIAL_SECTOR_WRITE_CMD, SPECIAL_SECTOR_READ_CMD,
    FAST_SPECIAL_SECTOR_READ_CMD};
  logic                    clk_i = 1'b0;
  logic                    sys_rst_i = 1'b1;
  logic                    wp_n_i = 1'b1;
  logic                    cs_n, sck, si, so_o, so_oe_o;
  logic [ARRAY_ADDR_W-1:0] mem_addr_o;
  logic                    mem_re_o, mem_we_o;
  logic [7:0]              mem_wdata_o;
  logic [7:0]              mem_rdata_i = 8'h00;
  logic [7:0]              mem [int];
  logic [7:0]              exp_mem [int];
  logic [5:0]              nv = 6'h00;
  logic                    exp_latch = 1'b0;
  int                      n_errors = 0;
  int                      check_count = 0;
  int                      wr_cnt = 0;

  // 100 ns system clock
  always #50 clk_i = ~clk_i;

  spi_host_model h (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_o), .so_oe_i(so_oe_o));

  spi_feram_command_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .mem_addr_o(mem_addr_o),
    .mem_re_o(mem_re_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));

  // ---------------------------------------------------------------
  // array model and expectations
  // ---------------------------------------------------------------
  // unwritten bytes follow the address so a wrong address shows
  function automatic logic [7:0] dflt(input int a);
    return a[7:0] ^ 8'ha5;
  endfunction
  function automatic logic [7:0] mem_at(input int a);
    return mem.exists(a) ? mem[a] : dflt(a);
  endfunction
  function automatic logic [7:0] exp_at(input int a);
    return exp_mem.exists(a) ? exp_mem[a] : dflt(a);
  endfunction
  // protected upper region per block-protect pair
  function automatic logic prot(input int a);
    case (nv[1:0])
      2'b00: return 1'b0;
      2'b01: return a >= 32'h0006_0000;
      2'b10: return a >= 32'h0004_0000;
      default: return 1'b1;
    endcase
  endfunction

  // one-cycle registered read, writes counted
  always @(posedge clk_i) begin
    if (mem_re_o === 1'b1) begin
      mem_rdata_i <= mem_at(int'(mem_addr_o));
    end
    if (mem_we_o === 1'b1) begin
      mem[int'(mem_addr_o)] = mem_wdata_o;
      wr_cnt++;
    end
  end

  // ---------------------------------------------------------------
  // checking and host sequences
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t ns: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    h.start();
    h.byte_x(op, r);
    h.stop();
    if (op == SET_LATCH_CMD) exp_latch = 1'b1;
    if (op == CLEAR_LATCH_CMD) exp_latch = 1'b0;
  endtask

  // two status bytes in one frame, random input meanwhile
  task automatic rd_status();
    logic [7:0] r;
    h.start();
    h.byte_x(STATUS_READ_CMD, r);
    repeat (2) begin
      h.byte_x(8'($urandom), r);
      check(32'(r), 32'({nv, exp_latch, 1'b0}), "status");
    end
    h.stop();
    check(32'(so_oe_o), 32'h0, "released");
  endtask

  task automatic wr_status(input logic [7:0] v);
    logic [7:0] r;
    h.start();
    h.byte_x(STATUS_WRITE_CMD, r);
    h.byte_x(v, r);
    h.stop();
    if (exp_latch && !(nv[5] && !wp_n_i)) nv = v[7:2];
    rd_status();
  endtask

  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] r;
    h.start();
    h.byte_x(op, r);
    for (int i = 2; i >= 0; i--) h.byte_x(a[8*i +: 8], r);
  endtask

  task automatic wr_array(input logic [23:0] a, input int n);
    logic [7:0] r;
    logic [7:0] d;
    int         p;
    hdr(ARRAY_WRITE_CMD, a);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      h.byte_x(d, r);
      p = int'(19'(a[18:0] + k));
      if (exp_latch && !prot(p)) exp_mem[p] = d;
    end
    h.stop();
    for (int k = 0; k < n; k++) begin
      p = int'(19'(a[18:0] + k));
      check(32'(mem_at(p)), 32'(exp_at(p)), "array byte");
    end
  endtask

  task automatic rd_array(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [7:0] r;
    hdr(op, a);
    if (op == FAST_ARRAY_READ_CMD) h.byte_x(8'($urandom), r);
    for (int k = 0; k < n; k++) begin
      h.byte_x(8'($urandom), r);
      check(32'(r), 32'(exp_at(int'(19'(a[18:0] + k)))), "read byte");
    end
    h.stop();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  r;
    logic [39:0] id;
    int          wc;
    void'($urandom(32'ha4d2));
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    h.tick(4);
    rd_status();
    wr_status(8'hfc);
    cmd(SET_LATCH_CMD);
    rd_status();
    wr_status({1'b1, 3'($urandom), 2'($urandom), 2'b01});
    wp_n_i = 1'b0; // pin settled between frames
    wr_status(8'h00);
    wp_n_i = 1'b1;
    wr_status({1'b0, 7'($urandom)});
    cmd(CLEAR_LATCH_CMD);
    rd_status();
    wr_array(24'($urandom), 2);
    // seven of eight opcode bits, then deselect
    h.start();
    for (int i = 7; i > 0; i--) h.bit_x(SET_LATCH_CMD[i], r[0]);
    h.stop();
    rd_status();
    cmd(SET_LATCH_CMD);
    for (int bp = 0; bp < 4; bp++) begin
      wr_status({4'h0, 2'(bp), 2'b00});
      for (int q = 0; q < 4; q++) wr_array({5'($urandom), 2'(q), 17'($urandom)}, 1);
    end
    wr_status(8'h00);
    wr_array({5'($urandom), 19'h7_fffe}, 3);
    // one full byte, then a cut-off one
    hdr(ARRAY_WRITE_CMD, 24'h00_0100);
    h.byte_x(8'h3c, r);
    for (int i = 0; i < 5; i++) h.bit_x(1'b1, r[0]);
    h.stop();
    exp_mem[32'h0000_0100] = 8'h3c;
    check(32'(mem_at(32'h0000_0100)), 32'h3c, "full byte");
    check(32'(mem_at(32'h0000_0101)), 32'(exp_at(32'h0000_0101)), "cut byte");
    rd_array(ARRAY_READ_CMD, {5'($urandom), 19'h7_fffe}, 4);
    rd_array(FAST_ARRAY_READ_CMD, {5'($urandom), 19'h7_ffff}, 3);
    // identifier, then one byte past its end
    h.start();
    h.byte_x(DEVICE_IDENT_READ_CMD, r);
    for (int i = 4; i >= 0; i--) h.byte_x(8'($urandom), id[8*i +: 8]);
    h.stop();
    check(id[39:8], DEVICE_IDENT_DEFAULT, "ident");
    check(32'(id[7:0]), 32'({8{DEVICE_IDENT_DEFAULT[0]}}), "ident hold");
    // clock idle high: status, a write and a wrapping read again
    h.set_mode(1'b1);
    rd_status();
    wr_array({5'($urandom), 19'($urandom)}, 2);
    rd_array(ARRAY_READ_CMD, {5'($urandom), 19'h7_ffff}, 2);
    h.set_mode(1'b0);
    for (int i = 0; i < 6; i++) begin
      wc = wr_cnt;
      hdr(DEC_ONLY[i], 24'($urandom));
      h.byte_x(8'($urandom), r);
      h.stop();
      check(32'(r), 32'hff, "silent code");
      check(32'(wr_cnt), 32'(wc), "no write");
    end
    rd_status();
    summarize();
  end

  // hang guard, about five times the expected run
  initial begin
    #8_000_000;
    n_errors++;
    summarize();
  end
endmodule // tb_top
